// ==== hw/idx_bit_alu.sv ====
// Arithmetic unit for the indexed add, bit force and fill operations.
`timescale 1ns/100ps
module idx_bit_alu
(
  input wire idx_decode_pkg::op_t op,
  input wire logic [idx_decode_pkg::DATA_W-1:0] acc,
  input wire logic [idx_decode_pkg::DATA_W-1:0] operand,
  input wire logic [2:0] bit_sel,
  output logic [idx_decode_pkg::DATA_W-1:0] result,
  output logic [4:0] flags
);
  import idx_decode_pkg::*;

  // Nine-bit sum keeps the carry out.
  logic [DATA_W:0] sum;
  // Low nibble sum gives the digit carry.
  logic [4:0] nib;
  // One-hot mask of the selected bit.
  logic [DATA_W-1:0] mask;

  assign sum = {1'b0, acc} + {1'b0, operand};
  assign nib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  assign mask = DATA_W'(1) << bit_sel;

  // ****************************************************************
  // Result selection.
  // ****************************************************************
  always_comb begin
    unique case (op)
      OP_ADD: result = sum[DATA_W-1:0];
      OP_BITSET: result = operand | mask;
      OP_FILL: result = ALL_ONES;
      OP_NONE: result = operand;            // No operation keeps the byte.
    endcase
  end

  // Flag values of the add; the caller only stores them for the add.
  always_comb begin
    flags = '0;
    flags[FLAG_C] = sum[DATA_W];
    flags[FLAG_DC] = nib[4];
    flags[FLAG_Z] = (sum[DATA_W-1:0] == '0);
    flags[FLAG_N] = sum[DATA_W-1];
    // Overflow when both inputs share a sign the sum lacks.
    flags[FLAG_OV] = (acc[7] == operand[7]) && (sum[7] != acc[7]);
  end

endmodule : idx_bit_alu

// ==== hw/idx_decode_pkg.sv ====
// Package of constants and types for the indexed-offset instruction unit.
package idx_decode_pkg;

  // ****************************************************************
  // Widths and address constants.
  // ****************************************************************
  localparam int DATA_W = 8;                       // Data byte width.
  localparam int ADDR_W = 12;                      // Data space address width.
  localparam int INSTR_W = 16;                     // Program word width.
  localparam logic [7:0] OFFSET_LIMIT = 8'h5F;     // Highest offset operand.
  localparam logic [7:0] ALL_ONES = 8'hFF;         // Fill value.
  localparam logic [ADDR_W-1:0] FP_RESET = 12'h000; // Frame pointer reset.
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;  // Accumulator reset.
  localparam logic [4:0] FLAGS_RESET = 5'h00;        // Status reset.

  // ****************************************************************
  // Opcode field positions and patterns.
  // ****************************************************************
  localparam int ACCESS_BIT = 8;                   // Access-select bit.
  localparam int DEST_BIT = 9;                     // Destination-select bit.
  localparam int BITNUM_LSB = 9;                   // Bit-number field base.
  localparam logic [5:0] ADD_OP = 6'h09;           // 0010_01 upper bits.
  localparam logic [3:0] BITSET_OP = 4'h8;         // 1000 upper bits.
  localparam logic [7:0] FILL_OP = 8'h68;          // 0110_1000 upper byte.

  // ****************************************************************
  // Status flag positions.
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;

  // Four phases of one instruction cycle.
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
  // Operation chosen by the decoder.
  typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_BITSET, OP_FILL} op_t;

endpackage : idx_decode_pkg

// ==== hw/idx_instr_unit.sv ====
// Decode and execute unit for indexed-offset byte and bit instructions.
`timescale 1ns/100ps
module idx_instr_unit
#(
  parameter int MEM_DEPTH = 4096 // Bytes of data memory.
)
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic EXT_INSTR_ENABLE_BIT,
  input wire logic [idx_decode_pkg::INSTR_W-1:0] INSTR,
  input wire logic [idx_decode_pkg::ADDR_W-1:0] FP_LOAD_VALUE,
  input wire logic FP_LOAD,
  output logic [idx_decode_pkg::ADDR_W-1:0] FRAME_POINTER,
  output logic [idx_decode_pkg::DATA_W-1:0] ACCUM,
  output logic [4:0] STATUS_FLAGS,
  output logic [1:0] PHASE,
  output logic INSTR_DONE,
  output logic [idx_decode_pkg::ADDR_W-1:0] LAST_ADDR,
  output logic [idx_decode_pkg::DATA_W-1:0] LAST_DATA
);
  import idx_decode_pkg::*;

  // ****************************************************************
  // Elaboration check.
  // ****************************************************************
  // The memory must fit inside the data address space.
  if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("MEM_DEPTH out of range");
  end

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [DATA_W-1:0] mem [MEM_DEPTH]; // Data memory, no reset.
  phase_t phase_reg; // Current phase.
  logic [INSTR_W-1:0] ir_reg; // Latched instruction word.
  op_t op_reg; // Decoded operation.
  logic [ADDR_W-1:0] ea_reg; // Effective address.
  logic [DATA_W-1:0] opnd_reg; // Operand byte read in Q2.
  logic [DATA_W-1:0] res_reg; // Result formed in Q3.
  logic [4:0] flg_reg; // Flags formed in Q3.
  logic [ADDR_W-1:0] frame_pointer_reg; // Frame pointer.
  logic [DATA_W-1:0] acc_reg; // Working register.
  logic [4:0] status_reg; // Status flags.
  logic done_reg; // Q4 write pulse.
  logic [ADDR_W-1:0] last_addr_reg; // Effective address of the last executed instruction.
  logic [DATA_W-1:0] last_data_reg; // Last written value.

  // ****************************************************************
  // Decode: combinational, consumed in Q1.
  // ****************************************************************
  // Extension enable gates every extended interpretation.
  wire ext_on = EXT_INSTR_ENABLE_BIT;
  wire [7:0] operand_f = INSTR[7:0];
  wire access_sel = INSTR[ACCESS_BIT];
  // Offset form only for access bank and a small operand.
  wire indexed = ext_on && !access_sel
                 && (operand_f <= OFFSET_LIMIT);
  wire is_add = (INSTR[15:10] == ADD_OP);
  wire is_bitset = (INSTR[15:12] == BITSET_OP);
  wire is_fill = (INSTR[15:8] == FILL_OP);
  op_t op_dec;
  // Only indexed forms run here; literal forms belong to the main core.
  assign op_dec = !indexed ? OP_NONE :
                  is_add ? OP_ADD :
                  is_bitset ? OP_BITSET :
                  is_fill ? OP_FILL : OP_NONE;
  // Twelve-bit wraparound of pointer plus offset.
  wire [ADDR_W-1:0] ea_dec =
    frame_pointer_reg + {{(ADDR_W-8){1'b0}}, operand_f};

  // ****************************************************************
  // Execute unit.
  // ****************************************************************
  logic [DATA_W-1:0] alu_res;
  logic [4:0] alu_flg;
  idx_bit_alu u_alu (
    .op(op_reg),
    .acc(acc_reg),
    .operand(opnd_reg),
    .bit_sel(ir_reg[BITNUM_LSB +: 3]),
    .result(alu_res),
    .flags(alu_flg)
  );

  // Write-back steering for Q4.
  wire to_acc = (op_reg == OP_ADD) && !ir_reg[DEST_BIT];
  wire to_mem = (op_reg != OP_NONE) && !to_acc;
  wire [ADDR_W-1:0] mem_idx = ea_reg;
  wire mem_ok = (32'(ea_reg) < MEM_DEPTH);

  // ****************************************************************
  // Phase sequencer and pipeline registers.
  // ****************************************************************
  // One instruction per four clocks; each phase does one job.
  phase_t phase_next; // Phase after this clock.
  assign phase_next = (phase_reg == PH_Q1) ? PH_Q2 :
                      (phase_reg == PH_Q2) ? PH_Q3 :
                      (phase_reg == PH_Q3) ? PH_Q4 : PH_Q1;
  // Named phase strobes keep the clocked blocks below short.
  wire in_q1 = (phase_reg == PH_Q1); // Decode phase.
  wire in_q2 = (phase_reg == PH_Q2); // Operand read phase.
  wire in_q3 = (phase_reg == PH_Q3); // Process phase.
  wire in_q4 = (phase_reg == PH_Q4); // Write-back phase.

  // Phase counter; reset parks it in the decode phase.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Q1: latch the word and what the decoder made of it.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ir_reg <= '0;
      op_reg <= OP_NONE;
      ea_reg <= '0;
    end else if (in_q1) begin // Decode.
      ir_reg <= INSTR;
      op_reg <= op_dec;
      ea_reg <= ea_dec;
    end
  end

  // Q2: read the operand; an address past the memory reads as zero.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      opnd_reg <= '0;
    end else if (in_q2) begin // Read operand.
      opnd_reg <= mem_ok ? mem[mem_idx] : '0;
    end
  end

  // Q3: hold result and flags, so Q4 writes settled values only.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      res_reg <= '0;
      flg_reg <= '0;
    end else if (in_q3) begin // Process.
      res_reg <= alu_res;
      flg_reg <= alu_flg;
    end
  end

  // Completion pulse, high for the one cycle after an executed Q4.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= in_q4 && (op_reg != OP_NONE);
    end
  end

  // Data memory write in Q4; no reset so it can map to RAM.
  always_ff @(posedge MCLK) begin
    if (!SRST && phase_reg == PH_Q4 && to_mem && mem_ok) begin
      mem[mem_idx] <= res_reg;
    end
  end

  // ****************************************************************
  // Architectural registers.
  // ****************************************************************
  // Pointer loads only between instructions to keep addresses stable.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      frame_pointer_reg <= FP_RESET;
    end else if (FP_LOAD && in_q4) begin
      frame_pointer_reg <= FP_LOAD_VALUE;
    end
  end

  // Working register; only an add with destination bit low writes it.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      acc_reg <= ACC_RESET;
    end else if (in_q4 && to_acc) begin
      acc_reg <= res_reg;
    end
  end

  // Status; bit force and fill leave the flags alone.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      status_reg <= FLAGS_RESET;
    end else if (in_q4 && op_reg == OP_ADD) begin
      status_reg <= flg_reg;
    end
  end

  // Trace of the last executed write, so the result is visible outside.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      last_addr_reg <= '0;
      last_data_reg <= '0;
    end else if (in_q4 && op_reg != OP_NONE) begin
      last_addr_reg <= ea_reg;
      last_data_reg <= res_reg;
    end
  end

  // Outputs straight from flip-flops.
  assign FRAME_POINTER = frame_pointer_reg;
  assign ACCUM = acc_reg;
  assign STATUS_FLAGS = status_reg;
  assign PHASE = phase_reg;
  assign INSTR_DONE = done_reg;
  assign LAST_ADDR = last_addr_reg;
  assign LAST_DATA = last_data_reg;

endmodule : idx_instr_unit

// ==== test/idx_instr_unit_chk.sv ====
// Checker of port timing and results for the indexed-offset unit.
`timescale 1ns/100ps
module idx_instr_unit_chk
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic EXT_INSTR_ENABLE_BIT,
  input wire logic [idx_decode_pkg::INSTR_W-1:0] INSTR,
  input wire logic [idx_decode_pkg::ADDR_W-1:0] FP_LOAD_VALUE,
  input wire logic FP_LOAD,
  input wire logic [idx_decode_pkg::ADDR_W-1:0] FRAME_POINTER,
  input wire logic [idx_decode_pkg::DATA_W-1:0] ACCUM,
  input wire logic [4:0] STATUS_FLAGS,
  input wire logic [1:0] PHASE,
  input wire logic INSTR_DONE,
  input wire logic [idx_decode_pkg::ADDR_W-1:0] LAST_ADDR,
  input wire logic [idx_decode_pkg::DATA_W-1:0] LAST_DATA
);
  import idx_decode_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // An indexed add finishing now; its word was taken four edges back.
  sequence add_done_s;
    INSTR_DONE && $past(INSTR[15:10], 4) == ADD_OP;
  endsequence
  phase_step_a: assert property (
    PHASE != 2'd3 |=> PHASE == $past(PHASE) + 2'd1) else $error("phase slip");
  done_phase_a: assert property (
    INSTR_DONE |-> PHASE == 2'd0 && $past(PHASE) == 2'd3)
    else $error("done out of phase");
  legal_done_a: assert property (
    INSTR_DONE |-> $past(EXT_INSTR_ENABLE_BIT, 4)
      && !$past(INSTR[ACCESS_BIT], 4) && $past(INSTR[7:0], 4) <= OFFSET_LIMIT)
    else $error("illegal word executed");
  fp_offset_a: assert property (
    INSTR_DONE |-> LAST_ADDR ==
      $past(FRAME_POINTER, 4) + 12'($past(INSTR[7:0], 4)))
    else $error("wrong target address");
  fill_ones_a: assert property (
    INSTR_DONE && $past(INSTR[15:8], 4) == FILL_OP |->
      LAST_DATA == ALL_ONES && $stable(STATUS_FLAGS)) else $error("bad fill");
  bit_force_a: assert property (
    INSTR_DONE && $past(INSTR[15:12], 4) == BITSET_OP |->
      LAST_DATA[$past(INSTR[11:9], 4)] && $stable(STATUS_FLAGS))
    else $error("bad bit force");
  add_dest_a: assert property (
    add_done_s |-> ($past(INSTR[DEST_BIT], 4) ? $stable(ACCUM)
      : ACCUM == LAST_DATA)) else $error("bad add destination");
  add_flags_a: assert property (
    add_done_s |-> STATUS_FLAGS[FLAG_Z] == (LAST_DATA == 8'h00)
      && STATUS_FLAGS[FLAG_N] == LAST_DATA[7]) else $error("bad add flags");
endmodule : idx_instr_unit_chk

bind idx_instr_unit idx_instr_unit_chk chk (.MCLK, .SRST,
  .EXT_INSTR_ENABLE_BIT, .INSTR, .FP_LOAD_VALUE, .FP_LOAD, .FRAME_POINTER,
  .ACCUM, .STATUS_FLAGS, .PHASE, .INSTR_DONE, .LAST_ADDR, .LAST_DATA);

// ==== test/tb_idx_instr_unit.sv ====
// Self-checking testbench for the indexed-offset instruction unit.
`timescale 1ns/100ps
module tb_idx_instr_unit;
  import idx_decode_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b0;
  logic fp_load = 1'b0;
  logic [INSTR_W-1:0] instr = 16'h0000;
  logic [ADDR_W-1:0] fp_val = 12'h000;
  logic [ADDR_W-1:0] fp, last_addr;
  logic [DATA_W-1:0] accum, last_data;
  logic [4:0] flags;
  logic [1:0] phase;
  logic done;
  int n_errors = 0;
  int checks_done = 0;

  idx_instr_unit dut (.MCLK(mclk), .SRST(srst), .EXT_INSTR_ENABLE_BIT(en),
    .INSTR(instr), .FP_LOAD_VALUE(fp_val), .FP_LOAD(fp_load),
    .FRAME_POINTER(fp), .ACCUM(accum), .STATUS_FLAGS(flags), .PHASE(phase),
    .INSTR_DONE(done), .LAST_ADDR(last_addr), .LAST_DATA(last_data));

  // Free-running clock, 100 ns period.
  initial begin
    forever #50 mclk = ~mclk;
  end

  // Compare one result, widened to twelve bits.
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("mismatches %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Wait, bounded, at falling edges until the unit shows phase p.
  task automatic sync(input logic [1:0] p);
    for (int i = 0; i < 8 && phase !== p; i++) @(negedge mclk);
    if (phase !== p) begin
      n_errors++;
      $display("BAD %0t phase never came", $time);
      summarize();
    end
  endtask : sync

  // Present a word in Q1 and wait out its four phases.
  task automatic run(input logic [15:0] op, input logic on);
    sync(2'd0);
    instr = op;
    en = on;
    repeat (4) @(negedge mclk);
  endtask : run

  // The pointer only loads on the Q4 edge, so aim at phase three.
  task automatic set_fp(input logic [11:0] v);
    sync(2'd3);
    fp_val = v;
    fp_load = 1'b1;
    @(negedge mclk);
    fp_load = 1'b0;
    chk(fp, v);
  endtask : set_fp

  task automatic sc_fill;
    set_fp(12'hA00);
    run({FILL_OP, 8'h2C}, 1'b1);
    chk({11'h000, done}, 12'h001);
    chk(last_addr, 12'hA2C);
    chk({4'h0, last_data}, 12'h0FF);
    run({FILL_OP, 8'h5F}, 1'b1);
    chk(last_addr, 12'hA5F);
  endtask : sc_fill

  // Accumulator starts at zero, target byte holds all ones.
  task automatic sc_add;
    run({ADD_OP, 2'b00, 8'h2C}, 1'b1);
    chk({4'h0, accum}, 12'h0FF);
    chk({7'h00, flags}, 12'h010);
    run({ADD_OP, 2'b00, 8'h2C}, 1'b1);
    chk({4'h0, accum}, 12'h0FE);
    chk({7'h00, flags}, 12'h013);
    run({ADD_OP, 2'b10, 8'h2C}, 1'b1);
    chk({4'h0, accum}, 12'h0FE);
    chk({4'h0, last_data}, 12'h0FD);
  endtask : sc_add

  // The byte now reads FDh, so forcing bit one restores all ones.
  task automatic sc_bitset;
    run({BITSET_OP, 3'd1, 1'b0, 8'h2C}, 1'b1);
    chk({4'h0, last_data}, 12'h0FF);
    chk({7'h00, flags}, 12'h013);
  endtask : sc_bitset

  // Every output must read zero, and the phase Q1, while reset holds.
  task automatic chk_cleared;
    chk(fp, 12'h000);
    chk({4'h0, accum}, 12'h000);
    chk({7'h00, flags}, 12'h000);
    chk({10'h000, phase}, 12'h000);
    chk({11'h000, done}, 12'h000);
    chk(last_addr, 12'h000);
    chk({4'h0, last_data}, 12'h000);
  endtask : chk_cleared

  // A reset in mid-run clears the unit, which then runs from pointer zero.
  task automatic sc_reset;
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    chk_cleared();
    srst = 1'b0;
    run({FILL_OP, 8'h10}, 1'b1);
    chk({11'h000, done}, 12'h001);
    chk(last_addr, 12'h010);
  endtask : sc_reset

  // Words that must leave the done pulse, the last address and the accumulator alone.
  task automatic sc_refuse;
    logic [15:0] ops [5] = '{16'h682C, 16'h692C, 16'h6860, 16'h0000,
      16'h242C};
    logic ons [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], ons[i]);
      chk({11'h000, done}, 12'h000);
      chk(last_addr, 12'hA2C);
      chk({4'h0, accum}, 12'h0FE);
    end
  endtask : sc_refuse

  initial begin
    repeat (16) @(negedge mclk);
    chk_cleared();
    srst = 1'b0;
    sc_fill();
    sc_add();
    sc_bitset();
    sc_refuse();
    sc_reset();
    summarize();
  end
endmodule : tb_idx_instr_unit
